// ---- crsr_pkg.sv ----
// What this block does
// - working register at E0h, resets zero
// - operand register F0h; quotient into working
// - stack top 81h resets 07h; call/return
// - push increments, pop decrements stack top
// - data pointer 16 bits: 82h low, 83h high
// - two pointers; F8h bit 0 selects one
// - status word D0h layout, resets zero
// - add/sub/adjust/rotate/bit ops update flags
// - multiply/divide clear carry; overflow if product above FFh or divisor zero
// - set-carry forces one, others unchanged
// - bank bits map 00h,08h,10h,18h register banks
// - parity follows working register every cycle
// - user flags free, hardware never touches
// - program space 0000h-1FFFh, config at top
// - vectors occupy 0000h-007Fh
// - config bit 2 moves code end
package crsr_pkg;
  // register indices, byte address is four times the index
  localparam logic [12:0] IDX_SP = 13'h0081;
  localparam logic [12:0] IDX_DPL = 13'h0082;
  localparam logic [12:0] IDX_DPH = 13'h0083;
  localparam logic [12:0] IDX_PSW = 13'h00d0;
  localparam logic [12:0] IDX_ACC = 13'h00e0;
  localparam logic [12:0] IDX_B = 13'h00f0;
  localparam logic [12:0] IDX_MISC_CONTROL_ONE = 13'h00f8;
  localparam logic [12:0] IDX_CONFIG_WORD_HIGH = 13'h1fff;
  localparam logic [12:0] IDX_OPCODE = 13'h0100;
  localparam logic [12:0] IDX_OPERAND = 13'h0101;
  localparam logic [12:0] IDX_POPDATA = 13'h0102;
  localparam logic [12:0] IDX_PC = 13'h0103;
  localparam logic [12:0] IDX_PROG_ADDR = 13'h0104;
  localparam logic [12:0] IDX_STATUS = 13'h0105;
  localparam logic [7:0] SP_RST = 8'h07;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // status word bits
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_F1 = 1;
  localparam int PSW_P = 0;
  localparam int MISC_CONTROL_ONE_SEL = 0;
  localparam logic [7:0] MISC_CONTROL_ONE_WMASK = 8'hdd;
  localparam int CFG_CRC_BIT = 2;
  localparam logic [1:0] CFG_SETTLE = 2'h3;
  // program space partition
  localparam logic [15:0] VEC_LAST = 16'h007f;
  localparam logic [15:0] EMU_FIRST = 16'h0d00;
  localparam logic [15:0] EMU_LAST = 16'h0fff;
  localparam logic [15:0] CKS_FIRST = 16'h1fe0;
  localparam logic [15:0] CODE_END_CHECK = 16'h1fdf;
  localparam logic [15:0] CODE_END_PLAIN = 16'h1fef;
  localparam logic [15:0] CFG_FIRST = 16'h1ff0;
  localparam logic [15:0] PROG_LAST = 16'h1fff;
  typedef enum logic [2:0] {
    RGN_VECTOR = 3'b000,
    RGN_USER = 3'b001,
    RGN_EMU = 3'b010,
    RGN_CHECKSUM = 3'b011,
    RGN_CONFIG = 3'b100,
    RGN_OUTSIDE = 3'b101
  } crsr_region_type;
  typedef enum logic [4:0] {
    OP_ADD = 5'b00000, OP_ADDC = 5'b00001, OP_SUBB = 5'b00010,
    OP_MUL = 5'b00011, OP_DIV = 5'b00100, OP_DA = 5'b00101,
    OP_RRC = 5'b00110, OP_RLC = 5'b00111, OP_SETBC = 5'b01000,
    OP_CLRC = 5'b01001, OP_CPLC = 5'b01010, OP_ANLC = 5'b01011,
    OP_ANLNC = 5'b01100, OP_ORLC = 5'b01101, OP_ORLNC = 5'b01110,
    OP_MOVC = 5'b01111, OP_CJNE = 5'b10000, OP_PUSH = 5'b10001,
    OP_POP = 5'b10010, OP_CALL = 5'b10011, OP_RET = 5'b10100
  } crsr_op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CALL_HI = 3'b001,
    ST_POP_A = 3'b010,
    ST_POP_B = 3'b011,
    ST_RET_A = 3'b100,
    ST_RET_B = 3'b101,
    ST_RET_C = 3'b110
  } crsr_fsm_type;
endpackage

// ---- crsr_stack_ram.sv ----
`timescale 1ns/1ns
module crsr_stack_ram (
  // clock
  input wire logic clk,
  // access
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// ---- crsr_core.sv ----
`timescale 1ns/1ns
module crsr_core import crsr_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // configuration word from program memory
  input wire logic [7:0] cfg_word_high,
  // core views
  output logic [4:0] bank_base,
  output logic [15:0] active_data_ptr
);
  typedef struct packed {
    crsr_fsm_type fsm;
    logic [7:0] acc, b, sp, status_word, misc_control_one, operand, pop_data;
    logic [1:0][15:0] data_ptr_pair;
    logic [15:0] pc, prog_addr, dp_out;
    logic [7:0] cfg, cfg_s1, cfg_s2, cfg_s3;
    logic [1:0] cfg_age;
    logic cfg_loaded;
    crsr_region_type region;
    logic [4:0] bank_base;
    logic wr_pend, rd_pend, hit;
    logic [12:0] idx;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
  } crsr_core_state_type;

  crsr_core_state_type s;
  crsr_core_state_type n;
  logic mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic op_fire;
  crsr_op_type op_code;

  assign op_fire = s.wr_pend && s.hreadyout && s.hit && (s.idx == IDX_OPCODE);
  assign op_code = crsr_op_type'(hwdata[4:0]);

  crsr_stack_ram u_stack (
    .clk(hclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  function automatic logic [31:0] rd_mux(input crsr_core_state_type t);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (t.hit) begin
      case (t.idx)
        IDX_SP: r[7:0] = t.sp;
        IDX_DPL: r[7:0] = t.data_ptr_pair[t.misc_control_one[MISC_CONTROL_ONE_SEL]][7:0];
        IDX_DPH: r[7:0] = t.data_ptr_pair[t.misc_control_one[MISC_CONTROL_ONE_SEL]][15:8];
        IDX_PSW: r[7:0] = t.status_word;
        IDX_ACC: r[7:0] = t.acc;
        IDX_B: r[7:0] = t.b;
        IDX_MISC_CONTROL_ONE: r[7:0] = t.misc_control_one;
        IDX_CONFIG_WORD_HIGH: r[7:0] = t.cfg;
        IDX_OPERAND: r[7:0] = t.operand;
        IDX_POPDATA: r[7:0] = t.pop_data;
        IDX_PC: r[15:0] = t.pc;
        IDX_PROG_ADDR: r[15:0] = t.prog_addr;
        IDX_STATUS: r[5:0] = {t.fsm != ST_IDLE, t.cfg_loaded,
                              t.cfg[CFG_CRC_BIT], t.region};
        default: r = 32'h0000_0000;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    logic sel;
    logic cin;
    logic wr_now;
    logic [8:0] t9;
    logic [4:0] t5;
    logic [15:0] prod;
    logic [15:0] code_end;
    sel = s.misc_control_one[MISC_CONTROL_ONE_SEL];
    cin = 1'b0;
    wr_now = s.wr_pend && s.hreadyout && s.hit;
    t9 = 9'h000;
    t5 = 5'h00;
    prod = 16'h0000;
    code_end = CODE_END_PLAIN;
    n = s;
    mem_we = 1'b0;
    mem_addr = s.sp;
    mem_wdata = s.operand;

    // stack sequencer for pop, second call byte and return
    unique case (s.fsm)
      ST_IDLE: begin
      end
      ST_CALL_HI: begin
        mem_we = 1'b1;
        mem_addr = s.sp + 8'h01;
        mem_wdata = s.pc[15:8];
        n.sp = s.sp + 8'h01;
        n.fsm = ST_IDLE;
      end
      ST_POP_A: begin
        n.fsm = ST_POP_B;
      end
      ST_POP_B: begin
        n.pop_data = mem_rdata;
        n.sp = s.sp - 8'h01;
        n.fsm = ST_IDLE;
      end
      ST_RET_A: begin
        n.fsm = ST_RET_B;
      end
      ST_RET_B: begin
        n.pc[15:8] = mem_rdata;
        n.sp = s.sp - 8'h01;
        mem_addr = s.sp - 8'h01;
        n.fsm = ST_RET_C;
      end
      ST_RET_C: begin
        n.pc[7:0] = mem_rdata;
        n.sp = s.sp - 8'h01;
        n.fsm = ST_IDLE;
      end
      default: n.fsm = ST_IDLE;
    endcase

    // register writes, data phase
    if (wr_now) begin
      case (s.idx)
        IDX_SP: n.sp = hwdata[7:0];
        IDX_DPL: n.data_ptr_pair[sel][7:0] = hwdata[7:0];
        IDX_DPH: n.data_ptr_pair[sel][15:8] = hwdata[7:0];
        IDX_PSW: n.status_word[7:1] = hwdata[7:1];
        IDX_ACC: n.acc = hwdata[7:0];
        IDX_B: n.b = hwdata[7:0];
        IDX_MISC_CONTROL_ONE: n.misc_control_one = hwdata[7:0] & MISC_CONTROL_ONE_WMASK;
        IDX_OPERAND: n.operand = hwdata[7:0];
        IDX_PC: n.pc = hwdata[15:0];
        IDX_PROG_ADDR: n.prog_addr = hwdata[15:0];
        default: begin
        end
      endcase
    end

    // core operation, one per opcode write
    if (op_fire) begin
      case (op_code)
        OP_ADD, OP_ADDC: begin
          cin = (op_code == OP_ADDC) && s.status_word[PSW_CY];
          t9 = {1'b0, s.acc} + {1'b0, s.operand} + {8'h00, cin};
          t5 = {1'b0, s.acc[3:0]} + {1'b0, s.operand[3:0]} + {4'h0, cin};
          n.acc = t9[7:0];
          n.status_word[PSW_CY] = t9[8];
          n.status_word[PSW_AC] = t5[4];
          n.status_word[PSW_OV] = (s.acc[7] == s.operand[7]) && (t9[7] != s.acc[7]);
        end
        OP_SUBB: begin
          cin = s.status_word[PSW_CY];
          t9 = {1'b0, s.acc} - {1'b0, s.operand} - {8'h00, cin};
          t5 = {1'b0, s.acc[3:0]} - {1'b0, s.operand[3:0]} - {4'h0, cin};
          n.acc = t9[7:0];
          n.status_word[PSW_CY] = t9[8];
          n.status_word[PSW_AC] = t5[4];
          n.status_word[PSW_OV] = (s.acc[7] != s.operand[7]) && (t9[7] != s.acc[7]);
        end
        OP_MUL: begin
          prod = s.acc * s.b;
          n.acc = prod[7:0];
          n.b = prod[15:8];
          n.status_word[PSW_CY] = 1'b0;
          n.status_word[PSW_OV] = |prod[15:8];
        end
        OP_DIV: begin
          n.status_word[PSW_CY] = 1'b0;
          n.status_word[PSW_OV] = (s.b == 8'h00);
          if (s.b != 8'h00) begin
            n.acc = s.acc / s.b;
            n.b = s.acc % s.b;
          end
        end
        OP_DA: begin
          t9 = {1'b0, s.acc};
          if (s.acc[3:0] > 4'h9 || s.status_word[PSW_AC]) begin
            t9 = t9 + 9'h006;
          end
          if (t9[8] || t9[7:4] > 4'h9 || s.status_word[PSW_CY]) begin
            t9 = t9 + 9'h060;
          end
          n.acc = t9[7:0];
          n.status_word[PSW_CY] = s.status_word[PSW_CY] | t9[8];
        end
        OP_RRC: begin
          n.acc = {s.status_word[PSW_CY], s.acc[7:1]};
          n.status_word[PSW_CY] = s.acc[0];
        end
        OP_RLC: begin
          n.acc = {s.acc[6:0], s.status_word[PSW_CY]};
          n.status_word[PSW_CY] = s.acc[7];
        end
        OP_SETBC: n.status_word[PSW_CY] = 1'b1;
        OP_CLRC: n.status_word[PSW_CY] = 1'b0;
        OP_CPLC: n.status_word[PSW_CY] = ~s.status_word[PSW_CY];
        OP_ANLC: n.status_word[PSW_CY] = s.status_word[PSW_CY] & s.operand[0];
        OP_ANLNC: n.status_word[PSW_CY] = s.status_word[PSW_CY] & ~s.operand[0];
        OP_ORLC: n.status_word[PSW_CY] = s.status_word[PSW_CY] | s.operand[0];
        OP_ORLNC: n.status_word[PSW_CY] = s.status_word[PSW_CY] | ~s.operand[0];
        OP_MOVC: n.status_word[PSW_CY] = s.operand[0];
        OP_CJNE: n.status_word[PSW_CY] = (s.acc < s.operand);
        OP_PUSH: begin
          mem_we = 1'b1;
          mem_addr = s.sp + 8'h01;
          n.sp = s.sp + 8'h01;
        end
        OP_POP: n.fsm = ST_POP_A;
        OP_CALL: begin
          mem_we = 1'b1;
          mem_addr = s.sp + 8'h01;
          mem_wdata = s.pc[7:0];
          n.sp = s.sp + 8'h01;
          n.fsm = ST_CALL_HI;
        end
        OP_RET: n.fsm = ST_RET_A;
        default: begin
        end
      endcase
    end

    // parity tracks the working register
    n.status_word[PSW_P] = ^n.acc;
    n.bank_base = {n.status_word[PSW_RS_HI], n.status_word[PSW_RS_LO], 3'b000};
    n.dp_out = n.data_ptr_pair[n.misc_control_one[MISC_CONTROL_ONE_SEL]];

    // configuration word capture after reset
    n.cfg_s1 = cfg_word_high;
    n.cfg_s2 = s.cfg_s1;
    n.cfg_s3 = s.cfg_s2;
    if (s.cfg_age != CFG_SETTLE) begin
      n.cfg_age = s.cfg_age + 2'h1;
    end else if (!s.cfg_loaded && s.cfg_s2 == s.cfg_s3) begin
      n.cfg = s.cfg_s3;
      n.cfg_loaded = 1'b1;
    end

    // program space partition of the probed address
    if (n.cfg[CFG_CRC_BIT]) begin
      code_end = CODE_END_CHECK;
    end
    if (n.prog_addr <= VEC_LAST) begin
      n.region = RGN_VECTOR;
    end else if (n.prog_addr > PROG_LAST) begin
      n.region = RGN_OUTSIDE;
    end else if (n.prog_addr >= CFG_FIRST) begin
      n.region = RGN_CONFIG;
    end else if (n.prog_addr > code_end) begin
      n.region = RGN_CHECKSUM;
    end else if (n.prog_addr >= EMU_FIRST && n.prog_addr <= EMU_LAST) begin
      n.region = RGN_EMU;
    end else begin
      n.region = RGN_USER;
    end

    // bus address phase
    if (hsel && htrans[1] && hready) begin
      n.wr_pend = hwrite;
      n.rd_pend = !hwrite;
      n.idx = haddr[14:2];
      n.hit = (haddr[31:15] == 17'h00000) && (hsize == HSIZE_WORD);
    end else if (s.hreadyout) begin
      n.wr_pend = 1'b0;
      n.rd_pend = 1'b0;
    end
    n.hreadyout = (n.fsm == ST_IDLE);
    n.hrdata = n.rd_pend ? rd_mux(n) : 32'h0000_0000;
    n.hresp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.sp <= SP_RST;
      s.hreadyout <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign bank_base = s.bank_base;
  assign active_data_ptr = s.dp_out;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence push_seq;
    op_fire && op_code == OP_PUSH;
  endsequence
  sequence call_seq;
    op_fire && op_code == OP_CALL;
  endsequence
  sequence pop_seq;
    op_fire && op_code == OP_POP;
  endsequence

  add_result_a: assert property (
    op_fire && op_code == OP_ADD |=>
      s.acc == 8'($past(s.acc) + $past(s.operand)))
    else $error("add result wrong");
  div_quotient_a: assert property (
    op_fire && op_code == OP_DIV && s.b != 8'h00 |=>
      s.acc == 8'($past(s.acc) / $past(s.b)) && !s.status_word[PSW_OV])
    else $error("divide quotient wrong");
  call_pushes_a: assert property (
    call_seq |-> ##2 s.sp == 8'($past(s.sp, 2) + 8'h02) && s.hreadyout)
    else $error("call did not push two bytes");
  push_sp_a: assert property (
    push_seq |=> s.sp == 8'($past(s.sp) + 8'h01))
    else $error("push did not raise stack top");
  pop_sp_a: assert property (
    pop_seq |-> ##3 s.sp == 8'($past(s.sp, 3) - 8'h01))
    else $error("pop did not lower stack top");
  data_ptr_pair_sel_a: assert property (
    s.wr_pend && s.hreadyout && s.hit && s.idx == IDX_DPL |=>
      s.data_ptr_pair[$past(s.misc_control_one[MISC_CONTROL_ONE_SEL])][7:0] == $past(hwdata[7:0]))
    else $error("wrong data pointer written");
  mul_flags_a: assert property (
    op_fire && op_code == OP_MUL |=>
      !s.status_word[PSW_CY] && s.status_word[PSW_OV] == (s.b != 8'h00))
    else $error("multiply flags wrong");
  setb_keep_a: assert property (
    op_fire && op_code == OP_SETBC |=>
      s.status_word[PSW_CY] && $stable(s.status_word[PSW_OV]) && $stable(s.status_word[PSW_AC]))
    else $error("set carry wrong");
  bank_map_a: assert property (
    s.wr_pend && s.hreadyout && s.hit && s.idx == IDX_PSW |=> s.bank_base[4:3] == $past(hwdata[4:3]))
    else $error("bank base wrong");
  parity_track_a: assert property (
    s.wr_pend && s.hreadyout && s.hit && s.idx == IDX_ACC |=> s.status_word[PSW_P] == ^$past(hwdata[7:0]))
    else $error("parity stale");
  user_flags_a: assert property (
    op_fire |=> $stable(s.status_word[PSW_F0]) && $stable(s.status_word[PSW_F1]))
    else $error("user flag touched by hardware");
  code_end_a: assert property (
    s.cfg[CFG_CRC_BIT] && s.prog_addr >= CKS_FIRST &&
      s.prog_addr <= CODE_END_PLAIN |-> s.region == RGN_CHECKSUM)
    else $error("checksum area not reserved");
  aux_reserved_a: assert property (
    (s.misc_control_one & ~MISC_CONTROL_ONE_WMASK) == 8'h00)
    else $error("reserved control bit set");
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top import crsr_pkg::*;;
  typedef struct packed {
    logic [12:0] wi;
    logic [15:0] wd;
    logic [12:0] ri;
    logic [15:0] m;
    logic [15:0] e;
  } crsr_row_type;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] cfg_word_high;
  logic [4:0] bank_base;
  logic [15:0] active_data_ptr;
  int failures, num_checks;
  // write index 0 means read only
  crsr_row_type rows[$] = '{
    '{13'h0,16'h0,IDX_SP,16'hff,16'h07},
    '{13'h0,16'h0,IDX_DPL,16'hff,16'h0},
    '{13'h0,16'h0,IDX_DPH,16'hff,16'h0},
    '{13'h0,16'h0,IDX_PSW,16'hff,16'h0},
    '{13'h0,16'h0,IDX_ACC,16'hff,16'h0},
    '{13'h0,16'h0,IDX_B,16'hff,16'h0},
    '{13'h0,16'h0,IDX_MISC_CONTROL_ONE,16'hff,16'h0},
    '{13'h0,16'h0,IDX_CONFIG_WORD_HIGH,16'hff,16'h04},
    '{13'h0,16'h0,IDX_STATUS,16'h3f,16'h18},
    '{13'h90,16'haa,13'h90,16'hff,16'h0},
    '{IDX_MISC_CONTROL_ONE,16'hff,IDX_MISC_CONTROL_ONE,16'hff,16'hdd},
    '{IDX_MISC_CONTROL_ONE,16'h0,IDX_MISC_CONTROL_ONE,16'hff,16'h0},
    '{IDX_SP,16'h5a,IDX_SP,16'hff,16'h5a},
    '{IDX_PSW,16'h3b,IDX_PSW,16'hff,16'h3a},
    '{IDX_PROG_ADDR,16'h7f,IDX_STATUS,16'h7,16'h0},
    '{IDX_PROG_ADDR,16'h80,IDX_STATUS,16'h7,16'h1},
    '{IDX_PROG_ADDR,16'hd00,IDX_STATUS,16'h7,16'h2},
    '{IDX_PROG_ADDR,16'hfff,IDX_STATUS,16'h7,16'h2},
    '{IDX_PROG_ADDR,16'h1fdf,IDX_STATUS,16'h7,16'h1},
    '{IDX_PROG_ADDR,16'h1fe0,IDX_STATUS,16'h7,16'h3},
    '{IDX_PROG_ADDR,16'h1ff0,IDX_STATUS,16'h7,16'h4},
    '{IDX_PROG_ADDR,16'h2000,IDX_STATUS,16'h7,16'h5},
    '{IDX_ACC,16'h7f,IDX_ACC,16'hff,16'h7f},
    '{IDX_OPERAND,16'h1,IDX_OPERAND,16'hff,16'h1},
    '{IDX_PSW,16'h0,IDX_PSW,16'hfe,16'h0},
    '{IDX_OPCODE,16'h0,IDX_PSW,16'hc4,16'h44},
    '{13'h0,16'h0,IDX_ACC,16'hff,16'h80},
    '{13'h0,16'h0,IDX_PSW,16'h1,16'h1},
    '{IDX_OPCODE,16'h8,IDX_PSW,16'hc4,16'hc4},
    '{IDX_PSW,16'ha2,IDX_PSW,16'ha2,16'ha2},
    '{IDX_OPCODE,16'h9,IDX_PSW,16'ha2,16'h22},
    '{IDX_OPCODE,16'ha,IDX_PSW,16'h80,16'h80},
    '{IDX_B,16'h4,IDX_B,16'hff,16'h4},
    '{IDX_OPCODE,16'h3,IDX_PSW,16'h84,16'h4},
    '{13'h0,16'h0,IDX_ACC,16'hff,16'h0},
    '{13'h0,16'h0,IDX_B,16'hff,16'h2},
    '{IDX_ACC,16'hd,IDX_ACC,16'hff,16'hd},
    '{IDX_B,16'h3,IDX_B,16'hff,16'h3},
    '{IDX_PSW,16'h84,IDX_PSW,16'h84,16'h84},
    '{IDX_OPCODE,16'h4,IDX_PSW,16'h84,16'h0},
    '{13'h0,16'h0,IDX_ACC,16'hff,16'h4},
    '{13'h0,16'h0,IDX_B,16'hff,16'h1},
    '{IDX_B,16'h0,IDX_B,16'hff,16'h0},
    '{IDX_OPCODE,16'h4,IDX_PSW,16'h84,16'h4},
    '{13'h0,16'h0,IDX_ACC,16'hff,16'h4},
    '{IDX_PSW,16'h80,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'h2,IDX_ACC,16'hff,16'h2},
    '{13'h0,16'h0,IDX_PSW,16'hc4,16'h0},
    '{IDX_OPERAND,16'hff,IDX_OPERAND,16'hff,16'hff},
    '{IDX_PSW,16'h80,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'h1,IDX_ACC,16'hff,16'h2},
    '{13'h0,16'h0,IDX_PSW,16'hc4,16'hc0},
    '{IDX_OPCODE,16'h6,IDX_ACC,16'hff,16'h81},
    '{13'h0,16'h0,IDX_PSW,16'h80,16'h0},
    '{IDX_OPCODE,16'h7,IDX_ACC,16'hff,16'h2},
    '{13'h0,16'h0,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'h9,IDX_PSW,16'h80,16'h0},
    '{IDX_OPCODE,16'h10,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'h9,IDX_PSW,16'h80,16'h0},
    '{IDX_OPCODE,16'hf,IDX_PSW,16'h80,16'h80},
    '{IDX_OPERAND,16'hfe,IDX_OPERAND,16'hff,16'hfe},
    '{IDX_OPCODE,16'hf,IDX_PSW,16'h80,16'h0},
    '{IDX_OPCODE,16'h8,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'hb,IDX_PSW,16'h80,16'h0},
    '{IDX_OPCODE,16'h8,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'hc,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'h9,IDX_PSW,16'h80,16'h0},
    '{IDX_OPCODE,16'he,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'hd,IDX_PSW,16'h80,16'h80},
    '{IDX_ACC,16'h9a,IDX_ACC,16'hff,16'h9a},
    '{IDX_PSW,16'h0,IDX_PSW,16'hc4,16'h0},
    '{IDX_OPCODE,16'h5,IDX_ACC,16'hff,16'h0},
    '{13'h0,16'h0,IDX_PSW,16'h80,16'h80},
    '{IDX_OPCODE,16'h15,IDX_ACC,16'hff,16'h0},
    '{IDX_SP,16'h7,IDX_SP,16'hff,16'h7},
    '{IDX_OPERAND,16'h5a,IDX_OPERAND,16'hff,16'h5a},
    '{IDX_OPCODE,16'h11,IDX_SP,16'hff,16'h8},
    '{IDX_OPERAND,16'ha5,IDX_OPERAND,16'hff,16'ha5},
    '{IDX_OPCODE,16'h11,IDX_SP,16'hff,16'h9},
    '{IDX_OPCODE,16'h12,IDX_POPDATA,16'hff,16'ha5},
    '{13'h0,16'h0,IDX_SP,16'hff,16'h8},
    '{IDX_PC,16'h1234,IDX_PC,16'hffff,16'h1234},
    '{IDX_OPCODE,16'h13,IDX_SP,16'hff,16'ha},
    '{IDX_OPCODE,16'h12,IDX_POPDATA,16'hff,16'h12},
    '{IDX_OPCODE,16'h12,IDX_POPDATA,16'hff,16'h34},
    '{IDX_OPCODE,16'h13,IDX_SP,16'hff,16'ha},
    '{IDX_PC,16'h0,IDX_PC,16'hffff,16'h0},
    '{IDX_OPCODE,16'h14,IDX_PC,16'hffff,16'h1234},
    '{13'h0,16'h0,IDX_SP,16'hff,16'h8},
    '{IDX_OPCODE,16'h12,IDX_POPDATA,16'hff,16'h5a},
    '{13'h0,16'h0,IDX_SP,16'hff,16'h7}
  };

  assign hready = hreadyout;

  crsr_core DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .cfg_word_high, .bank_base, .active_data_ptr
  );

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one single word transfer, waits on hready in both phases
  task automatic xfer(input logic w, input logic [12:0] idx, input logic [31:0] wd);
    int n;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {17'h0, idx, 2'b00};
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    rd = hrdata;
    chk("hready", {31'h0, hready}, 32'h1);
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic ptr_chk(input logic [15:0] exp);
    @(posedge hclk);
    chk("data_ptr_pair", {16'h0, active_data_ptr}, {16'h0, exp});
  endtask

  initial begin
    #(100 * 20000);
    failures++;
    end_sim();
  end

  initial begin
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = HSIZE_WORD;
    hresetn = 1'b0;
    cfg_word_high = 8'h04;
    repeat (4) @(posedge hclk);
    chk("rst_ready", {31'h0, hreadyout}, 32'h1);
    chk("rst_bank", {27'h0, bank_base}, 32'h0);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    foreach (rows[i]) begin
      if (rows[i].wi != 13'h0) xfer(1'b1, rows[i].wi, {16'h0, rows[i].wd});
      xfer(1'b0, rows[i].ri, 32'h0);
      rd = rd & {16'h0, rows[i].m};
      chk($sformatf("row%0d", i), rd, {16'h0, rows[i].e});
    end
    xfer(1'b1, IDX_DPL, 32'h34);
    xfer(1'b1, IDX_DPH, 32'h12);
    ptr_chk(16'h1234);
    xfer(1'b1, IDX_MISC_CONTROL_ONE, 32'h1);
    ptr_chk(16'h0);
    xfer(1'b0, IDX_DPL, 32'h0);
    chk("dpl_other", rd, 32'h0);
    xfer(1'b1, IDX_DPL, 32'h78);
    xfer(1'b1, IDX_DPH, 32'h56);
    ptr_chk(16'h5678);
    xfer(1'b1, IDX_MISC_CONTROL_ONE, 32'h0);
    ptr_chk(16'h1234);
    xfer(1'b0, IDX_DPH, 32'h0);
    chk("dph_back", rd, 32'h12);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, IDX_PSW, {27'h0, k[1:0], 3'h0});
      @(posedge hclk);
      chk("bank", {27'h0, bank_base}, {27'h0, k[1:0], 3'h0});
    end
    // reset in mid-run with the check option off
    cfg_word_high <= 8'h00;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("rst_ptr", {16'h0, active_data_ptr}, 32'h0);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    xfer(1'b1, IDX_PROG_ADDR, 32'h1fe0);
    xfer(1'b0, IDX_STATUS, 32'h0);
    chk("region_plain", rd & 32'h1f, 32'h11);
    xfer(1'b0, IDX_SP, 32'h0);
    chk("sp_rst", rd, 32'h7);
    xfer(1'b0, IDX_CONFIG_WORD_HIGH, 32'h0);
    chk("cfg_rst", rd, 32'h0);
    end_sim();
  end
endmodule
